// >>> core/cfg_header_pkg.sv
package cfg_header_pkg;

   // Configuration dword indices
   localparam logic [5:0]  DW_CMD_STATUS     = 6'h01;
   localparam logic [5:0]  DW_REV_CLASS      = 6'h02;
   localparam logic [5:0]  DW_CLS_LT_HDR     = 6'h03;
   localparam logic [5:0]  DW_CAP_PTR        = 6'h0d;

   // Byte offsets of the registers
   localparam logic [7:0]  OFS_BUS_STATUS    = 8'h06;
   localparam logic [7:0]  OFS_REVISION      = 8'h08;
   localparam logic [7:0]  OFS_CLASS         = 8'h09;
   localparam logic [7:0]  OFS_CACHE_LINE    = 8'h0c;
   localparam logic [7:0]  OFS_LATENCY       = 8'h0d;
   localparam logic [7:0]  OFS_HEADER        = 8'h0e;
   localparam logic [7:0]  OFS_CAP_POINTER   = 8'h34;

   // Status field positions (within the 16-bit status word)
   localparam int          ST_FAST_BUS_BIT   = 5;
   localparam int          ST_CAP_LIST_BIT   = 4;
   localparam logic        FAST_BUS_CAPABLE  = 1'b0;
   localparam logic        CAP_LIST_PRESENT  = 1'b1;

   // Class code bytes
   localparam logic [7:0]  BASE_CLASS_SERIAL = 8'h0c;
   localparam logic [7:0]  SUB_CLASS_USB_HC  = 8'h03;
   localparam logic [7:0]  PROG_IF_FULL_LOW  = 8'h10;
   localparam logic [7:0]  PROG_IF_HIGH      = 8'h20;

   // Header type fields
   localparam int          HDR_MULTI_FN_BIT  = 7;
   localparam logic        MULTI_FN_RESET    = 1'b1;
   localparam logic [6:0]  HDR_LAYOUT_RESET  = 7'h00;

   localparam logic [7:0]  CAP_POINTER_VALUE = 8'hdc;
   localparam logic [7:0]  CLS_RESET         = 8'h00;
   localparam logic [7:0]  LT_RESET          = 8'h00;
   // Arbitrary revision value
   localparam logic [7:0]  REVISION_DEFAULT  = 8'h01;

   // Memory bus commands
   localparam logic [3:0]  CMD_MEM_READ      = 4'h6;
   localparam logic [3:0]  CMD_MEM_WRITE     = 4'h7;
   localparam logic [3:0]  CMD_READ_MULTIPLE = 4'hc;
   localparam logic [3:0]  CMD_READ_LINE     = 4'he;
   localparam logic [3:0]  CMD_WRITE_INVAL   = 4'hf;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic [5:0]  dword;
      logic [3:0]  byte_en;
      logic [31:0] wdata;
   } cfg_req_s;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic [7:0]  addr_dw;
      logic [7:0]  len_dw;
   } mst_req_s;

endpackage : cfg_header_pkg

// >>> core/cfg_header_regs.sv
`timescale 1ns/100ps
`default_nettype none
module cfg_header_regs
   import cfg_header_pkg::*;
#(
   parameter logic [7:0] REVISION_ID = cfg_header_pkg::REVISION_DEFAULT
)
(
   input  wire logic                     ref_clk,         // Bus clock
   input  wire logic                     reset,           // Bus reset, active high
   input  wire logic                     hs_function_sel, // Strap: 1 for high-speed function
   input  wire cfg_header_pkg::cfg_req_s cfg_req,         // Configuration request
   output var  logic                     cfg_ack_r,       // Request done pulse
   output var  logic [31:0]              cfg_rdata_r,     // Read data
   input  wire cfg_header_pkg::mst_req_s mst_req,         // Master transfer request
   output var  logic                     mst_cmd_valid_r, // Command chosen pulse
   output var  logic [3:0]               mst_cmd_r,       // Chosen bus command
   input  wire logic                     mst_frame_start, // Master tenure begins
   input  wire logic                     mst_frame_end,   // Master tenure ends
   input  wire logic                     mst_gnt,         // Bus grant held
   output var  logic                     mst_quit_r,      // Tenure must end
   input  wire logic                     tgt_beat,        // Target burst data beat
   input  wire logic [7:0]               tgt_addr_dw,     // Target burst dword address
   output var  logic                     tgt_wrap_r       // Next beat wraps to line start
);
   import cfg_header_pkg::*;

   typedef enum logic [0:0] {T_IDLE, T_TENURE} tenure_e;

   logic    fn_hs_r;
   logic [7:0] cache_line_size_r;
   logic [7:0] master_latency_timer_r;
   logic [7:0] lat_cnt_r;
   logic [7:0] lat_cnt_nxt;
   tenure_e    tenure_r;
   tenure_e    tenure_nxt;

   // Read-only fields
   wire logic [7:0]  revision_identifier = REVISION_ID;
   wire logic [7:0]  base_class_byte     = BASE_CLASS_SERIAL;
   wire logic [7:0]  sub_class_byte      = SUB_CLASS_USB_HC;
   wire logic [7:0]  prog_interface_byte = fn_hs_r ? PROG_IF_HIGH : PROG_IF_FULL_LOW;
   wire logic        multi_function_flag = MULTI_FN_RESET;
   wire logic [6:0]  header_layout_code  = HDR_LAYOUT_RESET;
   wire logic        fast_bus_capable    = FAST_BUS_CAPABLE;
   wire logic        cap_list_present    = CAP_LIST_PRESENT;

   wire logic [15:0] bus_status = {10'h000, fast_bus_capable, cap_list_present, 4'h0};
   wire logic [23:0] function_class = {base_class_byte, sub_class_byte, prog_interface_byte};
   wire logic [7:0]  header_layout = {multi_function_flag, header_layout_code};

   // Read data per dword; unmapped dwords read zero
   wire logic [31:0] rd_status = {bus_status, 16'h0000};
   wire logic [31:0] rd_class  = {function_class, revision_identifier};
   wire logic [31:0] rd_hdr    = {8'h00, header_layout, master_latency_timer_r, cache_line_size_r};
   wire logic [31:0] rd_cap    = {24'h00_0000, CAP_POINTER_VALUE};
   wire logic [31:0] rd_mux    =
      (cfg_req.dword == DW_CMD_STATUS) ? rd_status :
      (cfg_req.dword == DW_REV_CLASS)  ? rd_class  :
      (cfg_req.dword == DW_CLS_LT_HDR) ? rd_hdr    :
      (cfg_req.dword == DW_CAP_PTR)    ? rd_cap    : 32'h0000_0000;

   // Only the two writable bytes respond to writes
   wire logic hit_hdr = cfg_req.valid && cfg_req.write && (cfg_req.dword == DW_CLS_LT_HDR);
   wire logic wr_cls  = hit_hdr && cfg_req.byte_en[0];
   wire logic wr_lt   = hit_hdr && cfg_req.byte_en[1];

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         fn_hs_r                <= hs_function_sel;
         cache_line_size_r      <= CLS_RESET;
         master_latency_timer_r <= LT_RESET;
      end
      else
      begin
         if (wr_cls)
            cache_line_size_r <= cfg_req.wdata[7:0];
         if (wr_lt)
            master_latency_timer_r <= cfg_req.wdata[15:8];
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         cfg_ack_r   <= 1'b0;
         cfg_rdata_r <= 32'h0000_0000;
      end
      else
      begin
         cfg_ack_r <= cfg_req.valid;
         if (cfg_req.valid && !cfg_req.write)
            cfg_rdata_r <= rd_mux;
      end
   end

   // Master command choice from the line size
   wire logic [7:0] line_mask  = cache_line_size_r - 8'h01;
   wire logic       cls_valid  = (cache_line_size_r != 8'h00);
   wire logic       line_align = ((mst_req.addr_dw & line_mask) == 8'h00);
   wire logic [3:0] read_cmd   =
      (!cls_valid || mst_req.len_dw <= 8'h01) ? CMD_MEM_READ :
      (mst_req.len_dw <= cache_line_size_r)  ? CMD_READ_LINE : CMD_READ_MULTIPLE;
   wire logic       mwi_ok     = cls_valid && line_align && (mst_req.len_dw == cache_line_size_r);
   wire logic [3:0] write_cmd  = mwi_ok ? CMD_WRITE_INVAL : CMD_MEM_WRITE;

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         mst_cmd_valid_r <= 1'b0;
         mst_cmd_r       <= CMD_MEM_READ;
      end
      else
      begin
         mst_cmd_valid_r <= mst_req.valid;
         if (mst_req.valid)
            mst_cmd_r <= mst_req.write ? write_cmd : read_cmd;
      end
   end

   // Latency timer: loaded at tenure start, counts down each bus clock
   always_comb
   begin
      tenure_nxt  = tenure_r;
      lat_cnt_nxt = lat_cnt_r;
      case (tenure_r)
         T_IDLE:
         begin
            if (mst_frame_start)
            begin
               tenure_nxt  = T_TENURE;
               lat_cnt_nxt = master_latency_timer_r;
            end
         end
         T_TENURE:
         begin
            if (mst_frame_end)
               tenure_nxt = T_IDLE;
            else if (lat_cnt_r != 8'h00)
               lat_cnt_nxt = lat_cnt_r - 8'h01;
         end
         default:
            tenure_nxt = T_IDLE;
      endcase
   end

   wire logic lat_expired = (tenure_r == T_TENURE) && (lat_cnt_r == 8'h00) && !mst_frame_end;

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         tenure_r   <= T_IDLE;
         lat_cnt_r  <= LT_RESET;
         mst_quit_r <= 1'b0;
      end
      else
      begin
         tenure_r   <= tenure_nxt;
         lat_cnt_r  <= lat_cnt_nxt;
         mst_quit_r <= lat_expired && !mst_gnt;
      end
   end

   // Wrap detection for cacheline-wrap bursts
   wire logic at_line_end = cls_valid && ((tgt_addr_dw & line_mask) == line_mask);

   always_ff @(posedge ref_clk)
   begin
      if (reset)
         tgt_wrap_r <= 1'b0;
      else
         tgt_wrap_r <= tgt_beat && at_line_end;
   end

   // Checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);

   sequence s_read(logic [5:0] dw);
      cfg_req.valid && !cfg_req.write && cfg_req.dword == dw;
   endsequence

   sequence s_idle;
      !cfg_req.valid;
   endsequence

   property p_status_bits;
      s_read(DW_CMD_STATUS) |=> cfg_ack_r && cfg_rdata_r[16+ST_FAST_BUS_BIT] == FAST_BUS_CAPABLE
         && cfg_rdata_r[16+ST_CAP_LIST_BIT] && cfg_rdata_r[19:16] == 4'h0;
   endproperty
   a_status_bits: assert property (p_status_bits) else $error("status bits wrong");

   property p_cap_ptr;
      s_read(DW_CAP_PTR) |=> cfg_rdata_r == {24'h00_0000, CAP_POINTER_VALUE};
   endproperty
   a_cap_ptr: assert property (p_cap_ptr) else $error("capability pointer wrong");

   property p_class_rev;
      s_read(DW_REV_CLASS) |=> cfg_rdata_r[7:0] == REVISION_ID
         && cfg_rdata_r[31:24] == BASE_CLASS_SERIAL && cfg_rdata_r[23:16] == SUB_CLASS_USB_HC;
   endproperty
   a_class_rev: assert property (p_class_rev) else $error("class or revision wrong");

   property p_prog_if;
      s_read(DW_REV_CLASS) |=> cfg_rdata_r[15:8] == (fn_hs_r ? PROG_IF_HIGH : PROG_IF_FULL_LOW);
   endproperty
   a_prog_if: assert property (p_prog_if) else $error("interface byte wrong");

   property p_header;
      s_read(DW_CLS_LT_HDR) |=> cfg_rdata_r[23:16] == {MULTI_FN_RESET, HDR_LAYOUT_RESET};
   endproperty
   a_header: assert property (p_header) else $error("header type wrong");

   property p_cls_write;
      (wr_cls ##1 s_idle ##1 s_read(DW_CLS_LT_HDR))
         |=> cfg_rdata_r[7:0] == $past(cfg_req.wdata[7:0], 3);
   endproperty
   a_cls_write: assert property (p_cls_write) else $error("line size not stored");

   property p_cls_reset;
      @(posedge ref_clk) disable iff (1'b0)
         reset |=> cache_line_size_r == CLS_RESET && master_latency_timer_r == LT_RESET;
   endproperty
   a_cls_reset: assert property (p_cls_reset) else $error("reset did not clear");

   property p_ro_write;
      (cfg_req.valid && cfg_req.write && cfg_req.dword != DW_CLS_LT_HDR)
         |=> cfg_ack_r && $stable(cache_line_size_r) && $stable(master_latency_timer_r);
   endproperty
   a_ro_write: assert property (p_ro_write) else $error("read-only write had effect");

   property p_read_cmd;
      (mst_req.valid && !mst_req.write && cache_line_size_r == 8'h00) |=> mst_cmd_r == CMD_MEM_READ;
   endproperty
   a_read_cmd: assert property (p_read_cmd) else $error("plain read expected");

   property p_latency;
      (tenure_r == T_IDLE && mst_frame_start && master_latency_timer_r == 8'h02)
         ##1 (!mst_frame_end && !mst_gnt) [*3] |=> mst_quit_r;
   endproperty
   a_latency: assert property (p_latency) else $error("latency timer did not expire");

   property p_wrap;
      (tgt_beat && cache_line_size_r == 8'h08 && tgt_addr_dw[2:0] == 3'h7) |=> tgt_wrap_r;
   endproperty
   a_wrap: assert property (p_wrap) else $error("wrap not flagged");

endmodule : cfg_header_regs
`default_nettype wire

// >>> verif/cfg_host_bridge.sv
`timescale 1ns/100ps
`default_nettype none
module cfg_host_bridge
   import cfg_header_pkg::*;
(
   input  wire logic                     ref_clk,     // Bus clock
   output var  cfg_header_pkg::cfg_req_s cfg_req,     // Request to the header
   input  wire logic                     cfg_ack_r,   // Done pulse
   input  wire logic [31:0]              cfg_rdata_r  // Read data
);
   initial cfg_req = '0;

   // One request; reply taken while the ack pulse stands, then idle with scrambled data
   task access(input logic wr, input logic [5:0] dw, input logic [3:0] be, input logic [31:0] wd,
               output logic [31:0] rd, output logic ack);
      @(negedge ref_clk);
      cfg_req <= '{1'b1, wr, dw, be, wd};
      @(negedge ref_clk);
      ack = cfg_ack_r;
      rd = cfg_rdata_r;
      cfg_req.valid <= 1'b0;
      cfg_req.wdata <= ~wd;
   endtask : access
endmodule : cfg_host_bridge
`default_nettype wire

// >>> verif/pci_config_header_id_regs_test.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
   $display("FAIL %s expected %h seen %h", n, e, g); end end
module pci_config_header_id_regs_test;
   import cfg_header_pkg::*;
   logic ref_clk = 0, reset = 1, hs_function_sel = 0;
   cfg_req_s cfg_req;
   mst_req_s mst_req = '0;
   logic cfg_ack_r, mst_cmd_valid_r, mst_quit_r, tgt_wrap_r, tgt_beat = 0;
   logic mst_frame_start = 0, mst_frame_end = 0, mst_gnt = 1;
   logic [31:0] cfg_rdata_r;
   logic [3:0] mst_cmd_r;
   logic [7:0] tgt_addr_dw = '0;
   logic [5:1] q;
   int n_mismatch = 0, comparisons = 0;
   // Each entry: write, start dword, length, expected command with line size 8
   localparam logic [20:0] MT [6] = '{{1'b0, 8'h00, 8'h01, 4'h6}, {1'b0, 8'h00, 8'h08, 4'he},
      {1'b0, 8'h00, 8'h09, 4'hc}, {1'b1, 8'h00, 8'h08, 4'hf}, {1'b1, 8'h04, 8'h08, 4'h7},
      {1'b1, 8'h00, 8'h04, 4'h7}};

   cfg_header_regs dut (.ref_clk(ref_clk), .reset(reset), .hs_function_sel(hs_function_sel),
      .cfg_req(cfg_req), .cfg_ack_r(cfg_ack_r), .cfg_rdata_r(cfg_rdata_r), .mst_req(mst_req),
      .mst_cmd_valid_r(mst_cmd_valid_r), .mst_cmd_r(mst_cmd_r), .mst_frame_start(mst_frame_start),
      .mst_frame_end(mst_frame_end), .mst_gnt(mst_gnt), .mst_quit_r(mst_quit_r),
      .tgt_beat(tgt_beat), .tgt_addr_dw(tgt_addr_dw), .tgt_wrap_r(tgt_wrap_r));
   cfg_host_bridge bridge (.ref_clk(ref_clk), .cfg_req(cfg_req), .cfg_ack_r(cfg_ack_r),
      .cfg_rdata_r(cfg_rdata_r));

   initial
   begin
      forever #12.5 ref_clk = ~ref_clk;
   end

   task results;
      $display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : results

   task do_reset(input logic hs);
      hs_function_sel <= hs;
      reset <= 1'b1;
      repeat (16) @(negedge ref_clk);
      reset <= 1'b0;
   endtask : do_reset

   task rd(input logic [5:0] dw, input logic [31:0] exp);
      logic [31:0] d;
      logic a;
      bridge.access(1'b0, dw, 4'h0, 32'h0000_0000, d, a);
      `CHK("read ack", 1'b1, a)
      `CHK("read data", exp, d)
   endtask : rd

   task wr(input logic [5:0] dw, input logic [3:0] be, input logic [31:0] wd);
      logic [31:0] d;
      logic a;
      bridge.access(1'b1, dw, be, wd, d, a);
      `CHK("write ack", 1'b1, a)
   endtask : wr

   task mcmd(input logic [20:0] t);
      @(negedge ref_clk);
      mst_req <= '{1'b1, t[20], t[19:12], t[11:4]};
      @(negedge ref_clk);
      `CHK("command valid", 1'b1, mst_cmd_valid_r)
      `CHK("command", t[3:0], mst_cmd_r)
      mst_req.valid <= 1'b0;
   endtask : mcmd

   initial
   begin
      do_reset(1'b0);
      rd(DW_CMD_STATUS, 32'h0010_0000);
      rd(DW_CAP_PTR, 32'h0000_00dc);
      rd(DW_REV_CLASS, {8'h0c, 8'h03, 8'h10, REVISION_DEFAULT});
      rd(DW_CLS_LT_HDR, 32'h0080_0000);
      mcmd({1'b0, 8'h00, 8'h04, 4'h6});
      wr(DW_CMD_STATUS, 4'hf, 32'hffff_ffff);
      wr(DW_REV_CLASS, 4'hf, 32'hffff_ffff);
      wr(6'h05, 4'hf, 32'hffff_ffff);
      wr(DW_CLS_LT_HDR, 4'hf, 32'hffff_ffff);
      rd(DW_CMD_STATUS, 32'h0010_0000);
      rd(DW_REV_CLASS, {8'h0c, 8'h03, 8'h10, REVISION_DEFAULT});
      rd(6'h05, 32'h0000_0000);
      rd(DW_CLS_LT_HDR, 32'h0080_ffff);
      wr(DW_CLS_LT_HDR, 4'h3, 32'hffff_0208);
      rd(DW_CLS_LT_HDR, 32'h0080_0208);
      foreach (MT[i]) mcmd(MT[i]);
      // Tenure with a two-clock timer and grant taken away
      @(negedge ref_clk);
      mst_gnt <= 1'b0;
      mst_frame_start <= 1'b1;
      @(negedge ref_clk);
      mst_frame_start <= 1'b0;
      for (int i = 1; i < 6; i++)
      begin
         @(negedge ref_clk);
         q[i] = mst_quit_r;
      end
      `CHK("quit timing", 5'b11100, q)
      mst_frame_end <= 1'b1;
      repeat (2) @(negedge ref_clk);
      mst_frame_end <= 1'b0;
      mst_gnt <= 1'b1;
      `CHK("quit after end", 1'b0, mst_quit_r)
      // Burst beats at the line's last dword, mid-line, and the next line's end
      tgt_beat <= 1'b1;
      tgt_addr_dw <= 8'h07;
      @(negedge ref_clk);
      `CHK("wrap at 7", 1'b1, tgt_wrap_r)
      tgt_addr_dw <= 8'h06;
      @(negedge ref_clk);
      `CHK("wrap at 6", 1'b0, tgt_wrap_r)
      tgt_addr_dw <= 8'h0f;
      @(negedge ref_clk);
      `CHK("wrap at f", 1'b1, tgt_wrap_r)
      tgt_beat <= 1'b0;
      do_reset(1'b1);
      rd(DW_CLS_LT_HDR, 32'h0080_0000);
      rd(DW_REV_CLASS, {8'h0c, 8'h03, 8'h20, REVISION_DEFAULT});
      results();
   end

   initial
   begin
      #100000;
      n_mismatch++;
      results();
   end
endmodule : pci_config_header_id_regs_test
`default_nettype wire
